// ==== verilog/csc_pkg.sv ====
package csc_pkg;
    localparam int CLK_PERIOD_NS = 25;
    localparam int LINK_PERIOD_NS = 200;
    localparam int LINK_CLK_CYCLES = LINK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int MAX_RES = 2048;

    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_TIMING = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_MCLK = 8'h0c;

    localparam int CTL_EN = 0;
    localparam int CTL_EMB = 1;
    localparam int CTL_VPOL = 2;
    localparam int CTL_HPOL = 3;
    localparam int CTL_PPOL = 4;
    localparam int CTL_GRAY = 5;
    localparam int CTL_GPACK = 6;
    localparam int CTL_CODEC = 7;
    localparam int CTL_SWAP = 8;
    localparam int CTL_FMT = 9;
    localparam int CTL_YORD = 11;
    localparam int CTL_RGBO = 13;
    localparam int CTL_SKIP = 16;
    localparam logic [31:0] CTRL_MASK = 32'h0007_7fff;
    localparam int TIM_SLD = 16;
    localparam int ST_LINES = 16;
    localparam int ST_INFRAME = 8;

    localparam logic [1:0] FMT_YCC = 2'h0;
    localparam logic [1:0] FMT_RGB888 = 2'h1;
    localparam logic [1:0] FMT_RGB565 = 2'h2;
    localparam logic [1:0] RGBO_MODE2 = 2'h2;

    localparam logic [7:0] CODE_FF = 8'hff;
    localparam logic [7:0] CODE_00 = 8'h00;
    localparam logic [7:0] CODE_SAV = 8'h80;
    localparam logic [7:0] CODE_EAV = 8'h9d;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== verilog/csc_capture.sv ====
`timescale 1ns/1ps
module csc_capture import csc_pkg::*; #(
    parameter int DATA_W = 12,
    parameter int SYS_CLK_PERIOD_NS = CLK_PERIOD_NS,
    parameter int PIX_CLK_PERIOD_NS = LINK_PERIOD_NS
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sensor_pixel_clk,
    input wire logic vert_sync_in,
    input wire logic horiz_sync_in,
    input wire logic [DATA_W-1:0] sensor_pixel_bus,
    output logic sensor_master_clk,
    output logic [31:0] pixel_word,
    output logic pixel_word_valid,
    output logic codec_word_valid,
    output logic frame_start_pulse,
    output logic frame_end_pulse,
    output logic sav_pulse,
    output logic eav_pulse
);
    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    // Edge finding by sampling needs several system clocks per pixel clock
    initial begin
        if (DATA_W != 12) $error("csc_capture: DATA_W must be 12");
        if (PIX_CLK_PERIOD_NS < 4 * SYS_CLK_PERIOD_NS) $error("csc_capture: system clock too slow");
    end

    function automatic logic [7:0] rev8(input logic [7:0] b);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            r[i] = b[7-i];
        end
        return r;
    endfunction

    function automatic logic [15:0] px565(input logic [7:0] f, input logic [7:0] s, input logic m2);
        logic [15:0] p;
        p = {f, s};
        if (m2) begin
            p = {f[4:0], s[2:0], f[7:5], s[7:3]};
        end
        return p;
    endfunction

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [31:0] ctrl_reg;
    logic [31:0] timing_reg;
    logic [3:0] sticky_reg;
    logic [7:0] mclk_div_reg;
    logic [11:0] last_lines_reg;
    logic [7:0] awaddr_reg;
    logic aw_have_reg;
    logic [31:0] wdata_reg;
    logic w_have_reg;
    logic [3:0] ev_now;

    wire en = ctrl_reg[CTL_EN];
    wire emb = ctrl_reg[CTL_EMB];
    wire gray = ctrl_reg[CTL_GRAY];
    wire gpack = ctrl_reg[CTL_GPACK];
    wire codec_en = ctrl_reg[CTL_CODEC];
    wire swap = ctrl_reg[CTL_SWAP];
    wire [1:0] fmt = ctrl_reg[CTL_FMT +: 2];
    wire [1:0] yord = ctrl_reg[CTL_YORD +: 2];
    wire [1:0] rgbo = ctrl_reg[CTL_RGBO +: 2];
    wire [2:0] skip = ctrl_reg[CTL_SKIP +: 3];
    wire [11:0] frame_start_blank_lines = timing_reg[11:0];
    wire [11:0] line_start_delay_cycles = timing_reg[TIM_SLD +: 12];

    wire aw_ok = s_axi_awvalid & s_axi_awready;
    wire w_ok = s_axi_wvalid & s_axi_wready;
    wire wr_go = (aw_have_reg | aw_ok) & (w_have_reg | w_ok) & ~s_axi_bvalid;
    wire [7:0] wr_addr = aw_have_reg ? awaddr_reg : s_axi_awaddr;
    wire [31:0] wr_data = w_have_reg ? wdata_reg : s_axi_wdata;
    wire [31:0] wr_mask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    wire wr_ctrl = wr_go & (wr_addr == OFS_CTRL);
    wire wr_tim = wr_go & (wr_addr == OFS_TIMING);
    wire wr_st = wr_go & (wr_addr == OFS_STATUS);
    wire wr_mck = wr_go & (wr_addr == OFS_MCLK);
    wire wr_hit = wr_ctrl | wr_tim | wr_st | wr_mck;
    wire [3:0] w1c = (wr_st & s_axi_wstrb[0]) ? wr_data[3:0] : 4'h0;
    wire rd_go = s_axi_arvalid & s_axi_arready;
    wire rd_hit = (s_axi_araddr == OFS_CTRL) | (s_axi_araddr == OFS_TIMING) |
                  (s_axi_araddr == OFS_STATUS) | (s_axi_araddr == OFS_MCLK);
    logic in_frame;
    wire [31:0] status_word = {4'h0, last_lines_reg, 7'h00, in_frame, 4'h0, sticky_reg};
    wire [31:0] rd_word = (s_axi_araddr == OFS_CTRL) ? ctrl_reg :
                          (s_axi_araddr == OFS_TIMING) ? timing_reg :
                          (s_axi_araddr == OFS_STATUS) ? status_word :
                          (s_axi_araddr == OFS_MCLK) ? {24'h0, mclk_div_reg} : 32'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (aw_ok & ~wr_go) begin
                aw_have_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (w_ok & ~wr_go) begin
                w_have_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_have_reg <= 1'b0;
                w_have_reg <= 1'b0;
                s_axi_awready <= 1'b0;
                s_axi_wready <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end else if (rd_go) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= 32'h0;
            timing_reg <= 32'h0;
            mclk_div_reg <= 8'h00;
            sticky_reg <= 4'h0;
        end else begin
            if (wr_ctrl) ctrl_reg <= ((ctrl_reg & ~wr_mask) | (wr_data & wr_mask)) & CTRL_MASK;
            if (wr_tim) timing_reg <= (timing_reg & ~wr_mask) | (wr_data & wr_mask);
            if (wr_mck & s_axi_wstrb[0]) mclk_div_reg <= wr_data[7:0];
            // A new event in the clearing cycle survives the clear
            sticky_reg <= (sticky_reg & ~w1c) | ev_now;
        end
    end

    // ------------------------------------------------------------
    // Sensor master clock
    // ------------------------------------------------------------
    logic [7:0] mck_cnt_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mck_cnt_reg <= 8'h00;
            sensor_master_clk <= 1'b0;
        end else if (mclk_div_reg == 8'h00) begin
            mck_cnt_reg <= 8'h00;
            sensor_master_clk <= 1'b0;
        end else if (mck_cnt_reg >= mclk_div_reg) begin
            mck_cnt_reg <= 8'h00;
            sensor_master_clk <= ~sensor_master_clk;
        end else begin
            mck_cnt_reg <= mck_cnt_reg + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // Input synchronisers and edge finding
    // ------------------------------------------------------------
    logic [DATA_W+2:0] sync1_reg;
    logic [DATA_W+2:0] sync2_reg;
    logic pck_d_reg;
    logic vs_d_reg;
    logic hs_d_reg;
    wire pck_s = sync2_reg[DATA_W+2] ^ ctrl_reg[CTL_PPOL];
    wire vs_act = sync2_reg[DATA_W+1] ^ ctrl_reg[CTL_VPOL];
    wire hs_act = sync2_reg[DATA_W] ^ ctrl_reg[CTL_HPOL];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            pck_d_reg <= 1'b0;
            vs_d_reg <= 1'b0;
            hs_d_reg <= 1'b0;
        end else begin
            sync1_reg <= {sensor_pixel_clk, vert_sync_in, horiz_sync_in, sensor_pixel_bus};
            sync2_reg <= sync1_reg;
            pck_d_reg <= pck_s;
            vs_d_reg <= vs_act;
            hs_d_reg <= hs_act;
        end
    end
    wire [DATA_W-1:0] din = sync2_reg[DATA_W-1:0];
    wire pck_edge = pck_s & ~pck_d_reg;

    // ------------------------------------------------------------
    // Frame and line timing
    // ------------------------------------------------------------
    logic [11:0] line_cnt_reg;
    logic [11:0] pix_cnt_reg;
    logic [11:0] pipe_reg [0:2];
    logic [2:0] tag_reg;
    logic in_line_reg;
    logic saw_sav_reg;
    logic vblank_reg;
    logic frame_act_reg;

    wire code_pre = (pipe_reg[2][7:0] == CODE_FF) & (pipe_reg[1][7:0] == CODE_00) & (pipe_reg[0][7:0] == CODE_00);
    wire code_hit = emb & pck_edge & code_pre;
    wire sav_hit = code_hit & (din[7:0] == CODE_SAV);
    wire eav_hit = code_hit & (din[7:0] == CODE_EAV);
    // Any other code, or an end code with no start since the last, marks blanking
    wire blank_hit = code_hit & ~sav_hit & (~eav_hit | ~saw_sav_reg);
    wire pin_fs = ~emb & vs_act & ~vs_d_reg;
    wire pin_fe = ~emb & ~vs_act & vs_d_reg;
    wire hs_edge = ~emb & hs_act & ~hs_d_reg;
    wire fs_hit = pin_fs | (sav_hit & vblank_reg);
    wire fe_hit = (pin_fe & frame_act_reg) | (blank_hit & ~vblank_reg & frame_act_reg);
    wire line_start = hs_edge | sav_hit;
    wire pin_byte_v = ~emb & pck_edge & vs_act & hs_act & (line_cnt_reg > frame_start_blank_lines) & (pix_cnt_reg >= line_start_delay_cycles);
    wire emb_byte_v = emb & pck_edge & tag_reg[2] & ~code_hit;
    wire byte_v = pin_byte_v | emb_byte_v;
    wire [DATA_W-1:0] byte_d = emb ? pipe_reg[2] : din;
    assign in_frame = frame_act_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pipe_reg[0] <= 12'h000;
            pipe_reg[1] <= 12'h000;
            pipe_reg[2] <= 12'h000;
            tag_reg <= 3'h0;
            in_line_reg <= 1'b0;
            saw_sav_reg <= 1'b0;
            vblank_reg <= 1'b1;
        end else if (emb & pck_edge) begin
            pipe_reg[0] <= din;
            pipe_reg[1] <= pipe_reg[0];
            pipe_reg[2] <= pipe_reg[1];
            // The code prefix bytes already queued must never reach the output
            tag_reg <= code_hit ? 3'h0 : {tag_reg[1:0], in_line_reg};
            if (sav_hit) begin
                in_line_reg <= 1'b1;
                saw_sav_reg <= 1'b1;
                vblank_reg <= 1'b0;
            end else if (code_hit) begin
                in_line_reg <= 1'b0;
                saw_sav_reg <= 1'b0;
                if (blank_hit) vblank_reg <= 1'b1;
            end
        end else if (~emb) begin
            tag_reg <= 3'h0;
            in_line_reg <= 1'b0;
            saw_sav_reg <= 1'b0;
            vblank_reg <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            line_cnt_reg <= 12'h000;
            pix_cnt_reg <= 12'h000;
            frame_act_reg <= 1'b0;
            last_lines_reg <= 12'h000;
        end else begin
            if (fs_hit) begin
                line_cnt_reg <= emb ? 12'h001 : 12'h000;
                frame_act_reg <= 1'b1;
            end else if (line_start & (line_cnt_reg != 12'hfff)) begin
                line_cnt_reg <= line_cnt_reg + 12'h001;
            end
            if (fe_hit) begin
                frame_act_reg <= 1'b0;
                last_lines_reg <= line_cnt_reg;
            end
            if (line_start) pix_cnt_reg <= 12'h000;
            else if (~emb & pck_edge & hs_act & (pix_cnt_reg != 12'hfff)) pix_cnt_reg <= pix_cnt_reg + 12'h001;
        end
    end

    // ------------------------------------------------------------
    // Frame rate counter
    // ------------------------------------------------------------
    logic [2:0] skip_cnt_reg;
    logic keep_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            skip_cnt_reg <= 3'h0;
            keep_reg <= 1'b0;
        end else if (fs_hit) begin
            keep_reg <= en & (skip_cnt_reg == 3'h0 || skip == 3'h0);
            skip_cnt_reg <= (skip_cnt_reg >= skip) ? 3'h0 : skip_cnt_reg + 3'h1;
        end else if (~en) begin
            keep_reg <= 1'b0;
            skip_cnt_reg <= 3'h0;
        end
    end

    // ------------------------------------------------------------
    // Byte ordering and word assembly
    // ------------------------------------------------------------
    logic [31:0] acc_reg;
    logic [1:0] idx_reg;
    wire rgb = (fmt == FMT_RGB888) | (fmt == FMT_RGB565);
    wire [7:0] cur = (swap & rgb) ? rev8(byte_d[7:0]) : byte_d[7:0];
    wire [1:0] last_idx = (fmt == FMT_RGB888) ? 2'h2 : 2'h3;
    wire take = byte_v & keep_reg & frame_act_reg;
    wire [7:0] b0 = acc_reg[7:0];
    wire [7:0] b1 = acc_reg[15:8];
    wire [7:0] b2 = (idx_reg == 2'h2) ? cur : acc_reg[23:16];
    wire [7:0] b3 = cur;
    wire [31:0] ycc_word = (yord == 2'h0) ? {b3, b2, b1, b0} :
                           (yord == 2'h1) ? {b3, b0, b1, b2} :
                           (yord == 2'h2) ? {b2, b3, b0, b1} : {b2, b1, b0, b3};
    wire [31:0] rgb888_word = {8'h00, b0, b1, b2};
    wire [31:0] rgb565_word = {px565(b2, b3, rgbo == RGBO_MODE2), px565(b0, b1, rgbo == RGBO_MODE2)};
    wire [31:0] color_word = (fmt == FMT_YCC) ? ycc_word :
                             (fmt == FMT_RGB888) ? rgb888_word : rgb565_word;
    wire [31:0] gray_word = gpack ? {byte_d, 4'h0, 16'h0000} : {acc_reg[11:0], 4'h0, byte_d, 4'h0};
    wire gray_done = take & (gpack | idx_reg[0]);
    wire color_done = take & (idx_reg == last_idx) & (fmt != 2'h3);
    wire word_done = gray ? gray_done : color_done;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc_reg <= 32'h0;
            idx_reg <= 2'h0;
        end else if (line_start | fs_hit) begin
            idx_reg <= 2'h0;
        end else if (take) begin
            if (word_done) begin
                idx_reg <= 2'h0;
            end else begin
                idx_reg <= idx_reg + 2'h1;
            end
            if (gray) acc_reg[11:0] <= byte_d;
            else acc_reg[8*idx_reg +: 8] <= cur;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pixel_word <= 32'h0;
            pixel_word_valid <= 1'b0;
            codec_word_valid <= 1'b0;
        end else begin
            pixel_word_valid <= word_done;
            codec_word_valid <= word_done & codec_en & ~gray;
            if (word_done) pixel_word <= gray ? gray_word : color_word;
        end
    end

    // ------------------------------------------------------------
    // Events
    // ------------------------------------------------------------
    assign ev_now = {eav_hit, sav_hit, fe_hit, fs_hit & en};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            frame_start_pulse <= 1'b0;
            frame_end_pulse <= 1'b0;
            sav_pulse <= 1'b0;
            eav_pulse <= 1'b0;
        end else begin
            frame_start_pulse <= ev_now[0];
            frame_end_pulse <= ev_now[1];
            sav_pulse <= ev_now[2];
            eav_pulse <= ev_now[3];
        end
    end
endmodule

// ==== verif/csc_capture_monitor.sv ====
`timescale 1ns/1ps
// ------------------------------
// Port checker
// ------------------------------
module csc_capture_monitor import csc_pkg::*; (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] pixel_word,
    input wire logic pixel_word_valid,
    input wire logic codec_word_valid,
    input wire logic frame_start_pulse,
    input wire logic sav_pulse,
    input wire logic eav_pulse
);
    logic [31:0] ctrl_reg;
    // Shadow of the control word; only valid while address and data arrive together
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= 32'h0;
        end else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr == OFS_CTRL) begin
            ctrl_reg <= s_axi_wdata;
        end
    end
    default clocking mcb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    codec_gated_a: assert property (codec_word_valid |-> pixel_word_valid && ctrl_reg[CTL_CODEC] && !ctrl_reg[CTL_GRAY])
        else $error("codec strobe out of mode");
    gray_pad_a: assert property (pixel_word_valid && ctrl_reg[CTL_GRAY] |-> pixel_word[19:16] == 4'h0 && pixel_word[3:0] == 4'h0)
        else $error("gray padding not zero");
    gray_single_a: assert property (pixel_word_valid && ctrl_reg[CTL_GRAY] && ctrl_reg[CTL_GPACK] |-> pixel_word[15:0] == 16'h0)
        else $error("single gray word has low half");
    rgb_top_a: assert property (pixel_word_valid && !ctrl_reg[CTL_GRAY] && ctrl_reg[10:9] == FMT_RGB888 |-> pixel_word[31:24] == 8'h0)
        else $error("rgb word top byte set");
    word_pulse_a: assert property (pixel_word_valid |=> !pixel_word_valid)
        else $error("word strobe too long");
    frame_once_a: assert property (frame_start_pulse |=> !frame_start_pulse [*8])
        else $error("frame start repeated");
    code_embedded_a: assert property (sav_pulse || eav_pulse |-> ctrl_reg[CTL_EMB] && !(sav_pulse && eav_pulse))
        else $error("code event out of mode");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
        else $error("no write response");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("no read response");
endmodule
bind csc_capture csc_capture_monitor i_mon (.*);

// ==== verif/csc_sensor_model.sv ====
`timescale 1ns/1ps
// ------------------------------
// Image sensor model
// ------------------------------
module csc_sensor_model import csc_pkg::*; (
    output logic sensor_pixel_clk,
    output logic vert_sync_in,
    output logic horiz_sync_in,
    output logic [11:0] sensor_pixel_bus
);
    initial begin
        sensor_pixel_clk = 1'b0;
        vert_sync_in = 1'b0;
        horiz_sync_in = 1'b0;
        sensor_pixel_bus = 12'h0;
    end
    task automatic park(input bit vl, input bit hl);
        vert_sync_in = vl;
        horiz_sync_in = hl;
    endtask
    // Own oscillator, slower than aclk, running only inside frames
    task automatic tick(input logic [11:0] d);
        sensor_pixel_bus = d;
        #(LINK_PERIOD_NS / 2) sensor_pixel_clk = 1'b1;
        #(LINK_PERIOD_NS / 2) sensor_pixel_clk = 1'b0;
    endtask
    task automatic frame(input bit emb, input bit vl, input bit hl, input int n, input logic [11:0] b [16]);
        int i;
        #400;
        if (!emb) vert_sync_in = !vl;
        #400;
        if (!emb) horiz_sync_in = !hl;
        for (i = 0; i < n; i++) tick(b[i]);
        horiz_sync_in = hl;
        // Released bus toggles so a stale byte cannot pass for data
        for (i = 0; i < 4; i++) tick(~sensor_pixel_bus);
        #400 vert_sync_in = vl;
        #400;
    endtask
endmodule

// ==== verif/test_camera_sensor_capture.sv ====
`timescale 1ns/1ps
module test_camera_sensor_capture import csc_pkg::*; ;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, sensor_pixel_clk, vert_sync_in, horiz_sync_in;
    logic sensor_master_clk, pixel_word_valid, codec_word_valid, frame_start_pulse, frame_end_pulse, sav_pulse, eav_pulse;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, pixel_word, seed, last_w, c, v, q;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [11:0] sensor_pixel_bus;
    logic [11:0] bt [16];
    int error_cnt, n_tests, nw, nc, nfs, nfe, nsv, nev, m, i;
    csc_capture i_dut (.*);
    csc_sensor_model i_sensor (.*);
    initial begin
        aclk = 1'b0;
        forever #(CLK_PERIOD_NS / 2.0) aclk = ~aclk;
    end
    always @(posedge aclk) begin
        nw <= nw + int'(pixel_word_valid === 1'b1);
        nc <= nc + int'(codec_word_valid === 1'b1);
        nfs <= nfs + int'(frame_start_pulse === 1'b1);
        nfe <= nfe + int'(frame_end_pulse === 1'b1);
        nsv <= nsv + int'(sav_pulse === 1'b1);
        nev <= nev + int'(eav_pulse === 1'b1);
        if (pixel_word_valid === 1'b1) last_w <= pixel_word;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("checks=%0d mismatches=%0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic axi(input bit wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
                       output logic [1:0] rs);
        int k;
        @(posedge aclk);
        if (wr) begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        end else begin
            s_axi_araddr <= a;
            {s_axi_arvalid, s_axi_rready} <= 2'h3;
        end
        for (k = 0; k < 50; k++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_bready && s_axi_bvalid) begin
                rs = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
            if (s_axi_rready && s_axi_rvalid) begin
                rs = s_axi_rresp;
                rd = s_axi_rdata;
                s_axi_rready <= 1'b0;
                break;
            end
        end
        if (k == 50) begin
            error_cnt++;
            close_out();
        end
    endtask
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [7:0] rv(input logic [7:0] x, input bit s);
        logic [7:0] y;
        for (int j = 0; j < 8; j++) y[j] = x[7 - j];
        return s ? y : x;
    endfunction
    function automatic logic [15:0] e565(input int o, input bit s, input bit md);
        logic [7:0] a, b;
        a = rv(bt[o][7:0], s);
        b = rv(bt[o + 1][7:0], s);
        return md ? {a[4:0], b[2:0], a[7:5], b[7:3]} : {a, b};
    endfunction
    // Memory byte order is Cb, Y0, Cr, Y1 from the low byte up
    function automatic logic [31:0] ycc(input int md, input int o);
        logic [7:0] a, b, e, d;
        a = bt[o][7:0];
        b = bt[o + 1][7:0];
        e = bt[o + 2][7:0];
        d = bt[o + 3][7:0];
        case (md)
            0: return {d, e, b, a};
            1: return {d, a, b, e};
            2: return {e, d, a, b};
            default: return {e, b, a, d};
        endcase
    endfunction
    task automatic run(input logic [31:0] cw, input logic [31:0] tim, input int n, input int nf, input int en,
                       input logic [31:0] ew);
        int w0, c0, s0, e0, k;
        axi(1'b1, OFS_CTRL, 32'h0, q, r);
        axi(1'b1, OFS_TIMING, tim, q, r);
        i_sensor.park(cw[CTL_VPOL], cw[CTL_HPOL]);
        axi(1'b1, OFS_CTRL, cw | 32'h1, q, r);
        // A polarity change can end a stale frame; let that event pass first
        repeat (4) @(posedge aclk);
        w0 = nw;
        c0 = nc;
        s0 = nfs;
        e0 = cw[CTL_EMB] ? nsv + nev : nfe;
        repeat (nf) i_sensor.frame(cw[CTL_EMB], cw[CTL_VPOL], cw[CTL_HPOL], n, bt);
        for (k = 0; k < 40 && nw - w0 < en; k++) @(posedge aclk);
        chk(32'(nw - w0), 32'(en));
        if (en > 0) chk(last_w, ew);
        chk(32'(nc - c0), (cw[CTL_CODEC] && !cw[CTL_GRAY]) ? 32'(en) : 32'h0);
        if (cw[18:16] == 3'h0) chk(32'(nfs - s0), 32'(nf));
        if (cw[18:16] == 3'h0) chk(32'((cw[CTL_EMB] ? nsv + nev : nfe) - e0), 32'(cw[CTL_EMB] ? 2 * nf : nf));
    endtask
    task automatic fill();
        for (int j = 0; j < 16; j++) bt[j] = rnd() & 32'hfff;
    endtask
    initial begin
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hf;
        seed = 32'h1b29;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        v = rnd() & 32'hffff_fffe;
        axi(1'b1, OFS_CTRL, v, q, r);
        axi(1'b0, OFS_CTRL, 32'h0, q, r);
        chk(q, v & CTRL_MASK);
        axi(1'b1, OFS_MCLK, 32'h3, q, r);
        chk(32'(r), 32'(RESP_OKAY));
        repeat (4) @(posedge aclk);
        v = 32'(sensor_master_clk);
        repeat (4) @(posedge aclk);
        chk(32'(sensor_master_clk), 32'(!v[0]));
        axi(1'b1, 8'hf0, v, q, r);
        chk(32'(r), 32'(RESP_SLVERR));
        axi(1'b0, 8'hf0, 32'h0, q, r);
        chk(32'(r), 32'(RESP_SLVERR));
        for (m = 0; m < 4; m++) begin
            fill();
            run((rnd() & 32'h8c) | (32'(m) << CTL_YORD), 32'h0, 4, 1, 1, ycc(m, 0));
            c = (rnd() & 32'h8c) | (32'(FMT_RGB565) << CTL_FMT) | (32'(m % 2) << CTL_SWAP);
            c = c | (32'(m / 2 == 1 ? RGBO_MODE2 : 2'h0) << CTL_RGBO);
            run(c, 32'h0, 4, 1, 1, {e565(2, m % 2, m / 2 == 1), e565(0, m % 2, m / 2 == 1)});
            c = (rnd() & 32'h8c) | (32'(FMT_RGB888) << CTL_FMT) | (32'(m % 2) << CTL_SWAP);
            run(c, 32'h0, 3, 1, 1, {8'h0, rv(bt[0][7:0], m % 2), rv(bt[1][7:0], m % 2), rv(bt[2][7:0], m % 2)});
        end
        for (m = 0; m < 2; m++) begin
            fill();
            c = (rnd() & 32'h8c) | 32'h20 | (32'(m) << CTL_GPACK);
            run(c, 32'h0, 2, 1, m + 1, m == 1 ? {bt[1], 20'h0} : {bt[0], 4'h0, bt[1], 4'h0});
        end
        fill();
        run(32'h0, 32'h4 << TIM_SLD, 8, 1, 1, ycc(0, 4));
        run(32'h0, 32'h1, 4, 1, 0, 32'h0);
        run(32'h1 << CTL_SKIP, 32'h0, 4, 2, 1, ycc(0, 0));
        // Blanking code first so the start code opens a frame
        for (i = 0; i < 16; i++) begin
            if (i < 8 || i > 11) bt[i] = (i % 4 == 0) ? 12'hff : (i % 4 == 3) ? {4'h0, i < 4 ? 8'hb6 : i < 8 ? CODE_SAV : CODE_EAV} : 12'h0;
            else bt[i] = bt[i] & 12'h07f;
        end
        run((rnd() & 32'h8c) | 32'h2, 32'h0, 16, 1, 1, ycc(0, 8));
        close_out();
    end
endmodule
